// *** core/mqfb_status.sv ***
`timescale 1ns/1ps
`default_nettype none
module mqfb_status
  import mqfb_pkg::*;
(
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     reset,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic                          pready,
  output logic                          pslverr,
  output logic [31:0]                   prdata,
  // Device pins
  input  wire mqfb_pkg::mqfb_pins_type  pins,
  // Datapath, same clock
  input  wire logic                     read_word_taken,
  input  wire logic                     read_word_end,
  input  wire logic                     output_valid_flag,
  // Status outputs, flags active low; bus syncs and packet_active active high
  output logic [7:0]                    almost_full_status_bus_n,
  output logic [7:0]                    almost_empty_status_bus_n,
  output logic                          full_bus_sync,
  output logic                          empty_bus_sync,
  output logic                          frame_ready_flag_n,
  output logic                          packet_active
);

  // ********************************
  // Pin synchroniser
  // ********************************
  mqfb_pins_type meta_q;
  mqfb_pins_type pin_q;

  // No reset: the straps must already stand in pin_q when reset
  // is released, or the capture below would see idle values
  always_ff @(posedge ref_clk) begin
    meta_q <= pins;
    pin_q  <= meta_q;
  end

  // ********************************
  // Strap capture after reset
  // ********************************
  logic       strap_done_q;
  logic [2:0] width_q;
  logic [2:0] dev_id_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      strap_done_q <= 1'b0;
      width_q      <= 3'h0;
      dev_id_q     <= 3'h0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      width_q      <= {pin_q.width_match_select, pin_q.input_width_select,
                       pin_q.output_width_select};
      dev_id_q     <= pin_q.device_id;
    end
  end

  // ********************************
  // Control registers
  // ********************************
  logic                     direct_q;
  logic                     packet_q;
  logic [COUNT_W-1:0]       count_q;
  logic [LEVEL_W-1:0]       af_off_q [QUEUES];
  logic [LEVEL_W-1:0]       ae_off_q [QUEUES];
  logic                     wr_acc;
  logic                     rd_setup;
  logic                     thr_hit;
  logic                     lvl_hit;
  logic [3:0]               reg_q;

  // Zero wait states
  assign pready  = 1'b1;
  assign wr_acc  = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign thr_hit = (paddr[7:6] == THRESH_BASE[7:6]) && (paddr[1:0] == 2'h0);
  assign lvl_hit = (paddr[7:6] == LEVEL_BASE[7:6]) && (paddr[1:0] == 2'h0);
  assign reg_q   = paddr[5:2];
  assign pslverr = psel && penable && !(paddr == CTRL_OFFSET
                   || (paddr == STATUS_OFFSET && !pwrite)
                   || thr_hit || (lvl_hit && !pwrite));

  // One mode bit for both buses
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      direct_q <= 1'b0;
      packet_q <= 1'b0;
      count_q  <= COUNT_RESET;
    end else if (wr_acc && paddr == CTRL_OFFSET) begin
      direct_q <= pwdata[CTRL_DIRECT_BIT];
      packet_q <= pwdata[CTRL_PACKET_BIT];
      count_q  <= pwdata[CTRL_COUNT_LSB +: COUNT_W];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int q = 0; q < QUEUES; q++) begin
        af_off_q[q] <= OFFSET_RESET;
        ae_off_q[q] <= OFFSET_RESET;
      end
    end else if (wr_acc && thr_hit) begin
      af_off_q[reg_q] <= pwdata[LEVEL_W-1:0];
      ae_off_q[reg_q] <= pwdata[AE_LSB +: LEVEL_W];
    end
  end

  assign packet_active = packet_q && strap_done_q && (width_q == 3'h0);

  // ********************************
  // Queue selection
  // ********************************
  logic [3:0] wq_q;
  logic       w_own_q;
  logic [3:0] rq_q;
  logic       r_own_q;

  // Device bits pick one of eight
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wq_q    <= 4'h0;
      w_own_q <= 1'b0;
    end else if (pin_q.write_addr_strobe) begin
      wq_q    <= pin_q.write_queue_address[3:0];
      w_own_q <= pin_q.write_queue_address[6:4] == dev_id_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rq_q    <= 4'h0;
      r_own_q <= 1'b0;
    end else if (pin_q.read_addr_strobe) begin
      rq_q    <= pin_q.read_queue_address[3:0];
      r_own_q <= pin_q.read_queue_address[6:4] == dev_id_q;
    end
  end

  // ********************************
  // Levels and frame tracking
  // ********************************
  logic [LEVEL_W-1:0] level_q  [QUEUES];
  logic [LEVEL_W-1:0] frames_q [QUEUES];
  logic [QUEUES-1:0]  in_frame_q;
  logic               wr_take;
  logic               rd_take;

  assign wr_take = !pin_q.write_en_n && w_own_q
                   && level_q[wq_q] != DEPTH_WORDS;
  assign rd_take = read_word_taken && r_own_q
                   && level_q[rq_q] != LEVEL_ZERO;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int q = 0; q < QUEUES; q++) begin
        level_q[q] <= LEVEL_ZERO;
      end
    end else begin
      for (int q = 0; q < QUEUES; q++) begin
        case ({wr_take && wq_q == q[3:0], rd_take && rq_q == q[3:0]})
          2'b10:   level_q[q] <= level_q[q] + LEVEL_ONE;
          2'b01:   level_q[q] <= level_q[q] - LEVEL_ONE;
          default: level_q[q] <= level_q[q];
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      in_frame_q <= '0;
    end else if (wr_take && packet_active) begin
      if (pin_q.write_data[END_BIT]) begin
        in_frame_q[wq_q] <= 1'b0;
      end else if (pin_q.write_data[START_BIT]) begin
        in_frame_q[wq_q] <= 1'b1;
      end
    end
  end

  // Complete frames counted; a write and a read in the same cycle leave the count unchanged
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int q = 0; q < QUEUES; q++) begin
        frames_q[q] <= LEVEL_ZERO;
      end
    end else begin
      for (int q = 0; q < QUEUES; q++) begin
        case ({wr_take && packet_active && wq_q == q[3:0]
               && pin_q.write_data[END_BIT]
               && (in_frame_q[q] || pin_q.write_data[START_BIT]),
               rd_take && packet_active && rq_q == q[3:0]
               && read_word_end && frames_q[q] != LEVEL_ZERO})
          2'b10:   frames_q[q] <= frames_q[q] + LEVEL_ONE;
          2'b01:   frames_q[q] <= frames_q[q] - LEVEL_ONE;
          default: frames_q[q] <= frames_q[q];
        endcase
      end
    end
  end

  // ********************************
  // Per-queue flags, active high
  // ********************************
  logic [QUEUES-1:0] af_flag;
  logic [QUEUES-1:0] ae_flag;
  logic [QUEUES-1:0] ready_flag;

  always_comb begin
    for (int q = 0; q < QUEUES; q++) begin
      // Sum widened by one bit so a large offset cannot wrap
      af_flag[q]    = {1'b0, level_q[q]} + {1'b0, af_off_q[q]}
                      >= {1'b0, DEPTH_WORDS};
      ae_flag[q]    = level_q[q] <= ae_off_q[q];
      ready_flag[q] = frames_q[q] != LEVEL_ZERO;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      frame_ready_flag_n <= 1'b1;
    end else begin
      frame_ready_flag_n <= !(packet_active && r_own_q
                              && ready_flag[rq_q] && output_valid_flag);
    end
  end

  // ********************************
  // Sector selection
  // ********************************
  logic f_sec_q;
  logic e_sec_q;
  logic f_sec_d;
  logic e_sec_d;

  always_comb begin
    f_sec_d = f_sec_q;
    e_sec_d = e_sec_q;
    if (!direct_q) begin
      f_sec_d = !f_sec_q;
      e_sec_d = !e_sec_q;
    end else begin
      // Full bus addressed by read port
      if (pin_q.full_bus_strobe
          && pin_q.read_queue_address[6:4] == dev_id_q) begin
        f_sec_d = pin_q.read_queue_address[3];
      end
      if (pin_q.empty_bus_strobe
          && pin_q.read_queue_address[6:4] == dev_id_q) begin
        e_sec_d = pin_q.read_queue_address[3];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      f_sec_q <= 1'b1;
      e_sec_q <= 1'b1;
    end else begin
      f_sec_q <= f_sec_d;
      e_sec_q <= e_sec_d;
    end
  end

  // ********************************
  // Status buses
  // ********************************
  logic [QUEUES-1:0] used;
  logic [QUEUES-1:0] e_src;

  always_comb begin
    for (int q = 0; q < QUEUES; q++) begin
      used[q] = q < count_q;
    end
  end

  assign e_src = packet_active ? ready_flag : ae_flag;

  // Both on the single clock here
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      almost_full_status_bus_n  <= 8'hFF;
      almost_empty_status_bus_n <= 8'hFF;
      full_bus_sync             <= 1'b0;
      empty_bus_sync            <= 1'b0;
    end else begin
      // One bit per queue of the sector
      almost_full_status_bus_n  <= f_sec_d
        ? ~(af_flag[15:8] & used[15:8]) : ~(af_flag[7:0] & used[7:0]);
      almost_empty_status_bus_n <= e_sec_d
        ? ~(e_src[15:8] & used[15:8]) : ~(e_src[7:0] & used[7:0]);
      full_bus_sync  <= !direct_q && !f_sec_d;
      empty_bus_sync <= !direct_q && !e_sec_d;
    end
  end

  // ********************************
  // Register read
  // ********************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= 32'h0000_0000;
      if (paddr == CTRL_OFFSET) begin
        prdata[CTRL_DIRECT_BIT]               <= direct_q;
        prdata[CTRL_PACKET_BIT]               <= packet_q;
        prdata[CTRL_COUNT_LSB +: COUNT_W]     <= count_q;
      end else if (paddr == STATUS_OFFSET) begin
        prdata[QUEUES-1:0]                    <= ready_flag;
        prdata[AE_LSB]                        <= packet_active;
        prdata[AE_LSB+3:AE_LSB+1]             <= width_q;
        prdata[AE_LSB+6:AE_LSB+4]             <= dev_id_q;
      end else if (thr_hit) begin
        prdata <= {ae_off_q[reg_q], af_off_q[reg_q]};
      end else if (lvl_hit) begin
        prdata <= {frames_q[reg_q], level_q[reg_q]};
      end
    end
  end

endmodule : mqfb_status
`default_nettype wire

// *** shared/mqfb_pkg.sv ***
package mqfb_pkg;

  // ********************************
  // Geometry
  // ********************************
  localparam int QUEUES       = 16;
  localparam int SECTOR_BITS  = 8;
  localparam int DEVICES      = 8;
  localparam int DEPTH        = 1024;
  localparam int LEVEL_W      = 16;
  localparam int WORD_W       = 36;
  localparam int START_BIT    = 34;
  localparam int END_BIT      = 35;
  localparam logic [LEVEL_W-1:0] DEPTH_WORDS = 16'h0400;
  localparam logic [LEVEL_W-1:0] LEVEL_ZERO  = 16'h0000;
  localparam logic [LEVEL_W-1:0] LEVEL_ONE   = 16'h0001;

  // ********************************
  // Register map (byte addresses)
  // ********************************
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] THRESH_BASE   = 8'h40;
  localparam logic [7:0] LEVEL_BASE    = 8'h80;

  // Control fields
  localparam int CTRL_DIRECT_BIT = 0;
  localparam int CTRL_PACKET_BIT = 1;
  localparam int CTRL_COUNT_LSB  = 4;
  localparam int COUNT_W         = 5;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 5'h10;
  // Threshold fields: full offset low half, empty offset high half
  localparam int AE_LSB = 16;
  localparam logic [LEVEL_W-1:0] OFFSET_RESET = 16'h0008;

  // ********************************
  // Pin inputs, sampled together
  // ********************************
  typedef struct packed {
    logic              write_en_n;
    logic [WORD_W-1:0] write_data;
    logic              write_addr_strobe;
    logic [6:0]        write_queue_address;
    logic              read_addr_strobe;
    logic [7:0]        read_queue_address;
    logic              empty_bus_strobe;
    logic              full_bus_strobe;
    logic              width_match_select;
    logic              input_width_select;
    logic              output_width_select;
    logic [2:0]        device_id;
  } mqfb_pins_type;

  localparam mqfb_pins_type PINS_IDLE = '{
    write_en_n: 1'b1, write_data: '0, write_addr_strobe: 1'b0,
    write_queue_address: '0, read_addr_strobe: 1'b0,
    read_queue_address: '0, empty_bus_strobe: 1'b0,
    full_bus_strobe: 1'b0, width_match_select: 1'b0,
    input_width_select: 1'b0, output_width_select: 1'b0,
    device_id: '0};

endpackage : mqfb_pkg

// *** sim/mqfb_status_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module mqfb_status_properties
  import mqfb_pkg::*;
(
  // Clock and reset
  input wire logic                    ref_clk,
  input wire logic                    reset,
  // Bus and pins
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire mqfb_pkg::mqfb_pins_type pins,
  input wire logic                    output_valid_flag,
  // Status outputs
  input wire logic [7:0]              almost_full_status_bus_n,
  input wire logic                    full_bus_sync,
  input wire logic                    empty_bus_sync,
  input wire logic                    frame_ready_flag_n,
  input wire logic                    packet_active
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_next_sector(sync);
    sync ##1 !sync;
  endsequence
  property p_empty_poll;
    empty_bus_sync |-> s_next_sector(empty_bus_sync);
  endproperty
  a_empty_poll: assert property (p_empty_poll)
    else $error("empty bus stayed on sector one");
  property p_full_poll;
    full_bus_sync |-> s_next_sector(full_bus_sync);
  endproperty
  a_full_poll: assert property (p_full_poll)
    else $error("full bus stayed on sector one");
  property p_common_mode;
    full_bus_sync |-> ##[0:1] empty_bus_sync;
  endproperty
  a_common_mode: assert property (p_common_mode)
    else $error("bus sync outputs disagree");
  property p_ready_access;
    psel && penable |-> pready;
  endproperty
  a_ready_access: assert property (p_ready_access)
    else $error("access phase without ready");
  property p_err_phase;
    pslverr |-> psel && penable;
  endproperty
  a_err_phase: assert property (p_err_phase)
    else $error("error outside access phase");
  property p_frame_valid;
    !frame_ready_flag_n |-> $past(output_valid_flag);
  endproperty
  a_frame_valid: assert property (p_frame_valid)
    else $error("frame ready without output valid");
  property p_pkt_width;
    packet_active |-> !(pins.width_match_select | pins.input_width_select
                        | pins.output_width_select);
  endproperty
  a_pkt_width: assert property (p_pkt_width)
    else $error("packet mode with narrow port");
  // Reset leaves both flag outputs inactive
  property p_reset_idle;
    $fell(reset) |-> almost_full_status_bus_n == 8'hFF && frame_ready_flag_n;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("flags active right after reset");
endmodule : mqfb_status_properties

bind mqfb_status mqfb_status_properties u_props (
  .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .pins(pins),
  .output_valid_flag(output_valid_flag),
  .almost_full_status_bus_n(almost_full_status_bus_n),
  .full_bus_sync(full_bus_sync), .empty_bus_sync(empty_bus_sync),
  .frame_ready_flag_n(frame_ready_flag_n), .packet_active(packet_active));
`default_nettype wire

// *** sim/mqfb_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mqfb_host_model
  import mqfb_pkg::*;
(
  // Clock
  input  wire logic                    ref_clk,
  // Queue port pins and read side
  output var mqfb_pkg::mqfb_pins_type  pins,
  output logic                         read_word_taken,
  output logic                         read_word_end,
  output logic                         output_valid_flag
);
  // ****************
  // Host side pins
  // ****************
  // straps low, all lines used
  initial begin
    pins = PINS_IDLE;
    read_word_taken = 1'b0;
    read_word_end = 1'b0;
    output_valid_flag = 1'b0;
  end
  task automatic put(input logic [35:0] d);
    @(posedge ref_clk);
    pins.write_en_n <= 1'b0;
    pins.write_data <= d;
    @(posedge ref_clk);
    pins.write_en_n <= 1'b1;
    // Stale data inverted so a late capture shows
    pins.write_data <= ~d;
  endtask : put
  // shared straps, set while reset is held
  task automatic strap(input logic [2:0] w, input logic [2:0] id);
    @(posedge ref_clk);
    {pins.width_match_select, pins.input_width_select,
     pins.output_width_select} <= w;
    pins.device_id <= id;
  endtask : strap
  task automatic sel_w(input logic [3:0] q);
    @(posedge ref_clk);
    pins.write_addr_strobe <= 1'b1;
    pins.write_queue_address <= {pins.device_id, q};
    @(posedge ref_clk);
    pins.write_addr_strobe <= 1'b0;
    pins.write_queue_address <= ~{pins.device_id, q};
  endtask : sel_w
  task automatic sel_r(input logic [7:0] a, input logic [2:0] s);
    @(posedge ref_clk);
    pins.read_queue_address <= a;
    {pins.full_bus_strobe, pins.empty_bus_strobe, pins.read_addr_strobe} <= s;
    @(posedge ref_clk);
    {pins.full_bus_strobe, pins.empty_bus_strobe, pins.read_addr_strobe} <= 3'h0;
    pins.read_queue_address <= ~a;
  endtask : sel_r
  task automatic take(input logic last);
    @(posedge ref_clk);
    read_word_taken <= 1'b1;
    read_word_end <= last;
    @(posedge ref_clk);
    read_word_taken <= 1'b0;
    read_word_end <= ~last;
  endtask : take
  task automatic valid(input logic v);
    @(posedge ref_clk);
    output_valid_flag <= v;
  endtask : valid
endmodule : mqfb_host_model
`default_nettype wire

// *** sim/tb_multiqueue_flag_bus_packet_mode.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_multiqueue_flag_bus_packet_mode;
  import mqfb_pkg::*;
  logic          ref_clk = 1'b0;
  logic          reset = 1'b1;
  logic          psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]    paddr, fbus, ebus;
  logic [31:0]   pwdata, prdata, rd;
  logic          fs, es, fr_n, pkt, rwt, rwe, ovf;
  mqfb_pins_type pins;
  int            n_errors = 0;
  int            compares = 0;

  always #2.5 ref_clk = ~ref_clk;

  mqfb_status dut (.ref_clk(ref_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .pins(pins),
    .read_word_taken(rwt), .read_word_end(rwe), .output_valid_flag(ovf),
    .almost_full_status_bus_n(fbus), .almost_empty_status_bus_n(ebus),
    .full_bus_sync(fs), .empty_bus_sync(es), .frame_ready_flag_n(fr_n),
    .packet_active(pkt));
  mqfb_host_model host (.ref_clk(ref_clk), .pins(pins),
    .read_word_taken(rwt), .read_word_end(rwe), .output_valid_flag(ovf));

  // ****************
  // Helpers
  // ****************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    check({31'h0, err}, {31'h0, e});
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic e);
    apb(1'b0, a, 32'h0);
    check({31'h0, err}, {31'h0, e});
    if (!e) check(rd, x);
  endtask : rdc
  // Masked bits belong to unconfigured queues
  function automatic logic [31:0] pack(input logic [1:0] s,
                                       input logic [7:0] f, e, m);
    return {14'h0, s, f & m, e & m};
  endfunction : pack
  task automatic look(input logic [1:0] s, input logic [7:0] f, e, m);
    @(negedge ref_clk);
    check(pack({fs, es}, fbus, ebus, m), pack(s, f, e, m));
  endtask : look
  task automatic poll(input logic [7:0] f1, e1, f2, e2, m);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (es !== 1'b1 && n < 4) begin
      @(negedge ref_clk);
      n++;
    end
    check(pack({fs, es}, fbus, ebus, 8'hFF), pack(2'b11, f1, e1, 8'hFF));
    look(2'b00, f2, e2, m);
  endtask : poll
  task automatic pause(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : pause

  // ****************
  // Tests
  // ****************
  initial begin
    {psel, penable, pwrite} = 3'b000;
    paddr = 8'h00;
    pwdata = 32'h0;
    pause(7);
    look(2'b00, 8'hFF, 8'hFF, 8'hFF);
    @(posedge ref_clk);
    reset <= 1'b0;
    pause(4);
    poll(8'hFF, 8'h00, 8'hFF, 8'h00, 8'hFF);
    rdc(CTRL_OFFSET, 32'h0000_0100, 1'b0);
    rdc(THRESH_BASE, 32'h0008_0008, 1'b0);
    rdc(8'h08, 32'h0, 1'b1);
    wr(STATUS_OFFSET, 32'h0, 1'b1);
    wr(THRESH_BASE + 8'h04, 32'h0008_03F7, 1'b0);
    host.sel_w(4'h1);
    repeat (9) host.put(36'h0_0000_00A5);
    pause(6);
    rdc(LEVEL_BASE + 8'h04, 32'h0000_0009, 1'b0);
    poll(8'hFD, 8'h02, 8'hFF, 8'h00, 8'hFF);
    wr(CTRL_OFFSET, 32'h0000_00E0, 1'b0);
    pause(4);
    poll(8'hFD, 8'h02, 8'hFF, 8'h00, 8'h3F);
    wr(CTRL_OFFSET, 32'h0000_00E1, 1'b0);
    host.sel_r(8'h08, 3'b010);
    host.sel_r(8'h00, 3'b100);
    pause(4);
    repeat (3) look(2'b00, 8'hFD, 8'h00, 8'h3F);
    host.sel_r(8'h00, 3'b010);
    pause(4);
    look(2'b00, 8'hFD, 8'h02, 8'hFF);
    wr(CTRL_OFFSET, 32'h0000_00E3, 1'b0);
    pause(4);
    check({31'h0, pkt}, 32'h1);
    look(2'b00, 8'hFD, 8'hFF, 8'hFF);
    // Open frame on queue 3 must not count
    host.sel_w(4'h3);
    host.put(36'h4_0000_0001);
    host.sel_w(4'h2);
    host.put(36'h4_0000_0011);
    host.put(36'h0_0000_0012);
    host.put(36'h8_0000_0013);
    pause(6);
    look(2'b00, 8'hFD, 8'hFB, 8'hFF);
    rdc(LEVEL_BASE + 8'h08, 32'h0001_0003, 1'b0);
    rdc(STATUS_OFFSET, 32'h0001_0004, 1'b0);
    host.sel_r(8'h02, 3'b001);
    host.valid(1'b1);
    pause(5);
    check({31'h0, fr_n}, 32'h0);
    host.valid(1'b0);
    pause(3);
    check({31'h0, fr_n}, 32'h1);
    host.valid(1'b1);
    host.take(1'b0);
    host.take(1'b0);
    host.take(1'b1);
    pause(5);
    look(2'b00, 8'hFD, 8'hFF, 8'hFF);
    check({31'h0, fr_n}, 32'h1);
    // Second reset: narrow straps, device number five
    @(posedge ref_clk);
    reset <= 1'b1;
    host.strap(3'b010, 3'h5);
    pause(6);
    reset <= 1'b0;
    pause(2);
    rdc(STATUS_OFFSET, 32'h0054_0000, 1'b0);
    wr(CTRL_OFFSET, 32'h0000_0102, 1'b0);
    pause(2);
    check({31'h0, pkt}, 32'h0);
    host.sel_w(4'h4);
    host.put(36'h0_0000_0044);
    // Read select for another device must leave the queue alone
    host.sel_r(8'h04, 3'b001);
    pause(2);
    host.take(1'b0);
    pause(6);
    rdc(LEVEL_BASE + 8'h10, 32'h0000_0001, 1'b0);
    end_of_test();
  end

  initial begin
    pause(5000);
    n_errors++;
    end_of_test();
  end
endmodule : tb_multiqueue_flag_bus_packet_mode
`default_nettype wire
